/* logic/twg_timer_output_waveform_gen.sv */
`timescale 1ns/1ps
module twg_timer_output_waveform_gen (
    // clock and reset
    input  wire logic        clk,
    input  wire logic        reset,
    // register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic      [15:0] reg_rdata,
    // counter events, same clock
    input  wire logic [1:0]  count_mode,
    input  wire logic        match_own,
    input  wire logic        match_partner,
    input  wire logic        counter_max,
    input  wire logic        counter_zero,
    // waveform
    output logic             timer_wave_out
);

    typedef struct packed {
        logic [15:0] ctl;
        logic        level;
        logic        out;
        logic [15:0] rdata;
    } twg_state_type;

    twg_state_type state_ff;
    twg_state_type nxt_state;

    logic                      capture_mode;
    logic                      paired;
    twg_pkg::twg_gen_mode_type gen_mode;
    logic                      set_ev;
    logic                      clr_ev;
    logic                      tgl_ev;
    logic                      period_ev;
    logic                      any_match;

    assign capture_mode = state_ff.ctl[twg_pkg::CAPTURE_MODE_BIT];
    assign paired = state_ff.ctl[twg_pkg::PAIR_SEL_BIT];
    assign gen_mode = twg_pkg::twg_gen_mode_type'(
        state_ff.ctl[twg_pkg::GEN_MODE_LSB +: 3]);
    assign any_match = match_own | match_partner;

    // end of period: zero when counting down, max otherwise
    assign period_ev = (count_mode == twg_pkg::COUNT_DOWN) ?
                       counter_zero : counter_max;

    //------------------------------------------------------------------
    // event decode
    //------------------------------------------------------------------
    always_comb begin
        set_ev = 1'b0;
        clr_ev = 1'b0;
        tgl_ev = 1'b0;
        case (gen_mode)
            twg_pkg::GEN_RESET_SET: begin
                clr_ev = match_own;
                set_ev = paired ? match_partner : period_ev;
            end
            twg_pkg::GEN_TOGGLE_SET: begin
                tgl_ev = match_own;
                set_ev = paired ? match_partner : period_ev;
            end
            twg_pkg::GEN_RESET: begin
                clr_ev = paired ? any_match : match_own;
            end
            twg_pkg::GEN_TOGGLE: begin
                tgl_ev = paired ? any_match : match_own;
            end
            twg_pkg::GEN_SET_RESET: begin
                set_ev = match_own;
                clr_ev = paired ? match_partner : period_ev;
            end
            twg_pkg::GEN_TOGGLE_RESET: begin
                tgl_ev = match_own;
                clr_ev = paired ? match_partner : period_ev;
            end
            twg_pkg::GEN_SET: begin
                set_ev = paired ? any_match : match_own;
            end
            default: begin
            end
        endcase
    end

    //------------------------------------------------------------------
    // next state
    //------------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_state.rdata = 16'h0000;
        if (reg_write && reg_addr == twg_pkg::CTL_ADDR) begin
            nxt_state.ctl = reg_wdata;
        end
        if (reg_read) begin
            case (reg_addr)
                twg_pkg::CTL_ADDR: nxt_state.rdata = state_ff.ctl;
                twg_pkg::STAT_ADDR: nxt_state.rdata = {15'h0000,
                                                       state_ff.level};
                default: nxt_state.rdata = 16'h0000;
            endcase
        end
        if (!capture_mode) begin
            if (gen_mode == twg_pkg::GEN_SOFTWARE) begin
                nxt_state.level = state_ff.ctl[twg_pkg::SW_LEVEL_BIT];
            end else begin
                case (gen_mode)
                    twg_pkg::GEN_RESET_SET,
                    twg_pkg::GEN_TOGGLE_SET: begin
                        if (set_ev) nxt_state.level = 1'b1;
                        else if (clr_ev) nxt_state.level = 1'b0;
                        else if (tgl_ev) nxt_state.level = ~state_ff.level;
                    end
                    twg_pkg::GEN_SET_RESET,
                    twg_pkg::GEN_TOGGLE_RESET: begin
                        if (clr_ev) nxt_state.level = 1'b0;
                        else if (set_ev) nxt_state.level = 1'b1;
                        else if (tgl_ev) nxt_state.level = ~state_ff.level;
                    end
                    default: begin
                        if (set_ev) nxt_state.level = 1'b1;
                        else if (clr_ev) nxt_state.level = 1'b0;
                        else if (tgl_ev) nxt_state.level = ~state_ff.level;
                    end
                endcase
            end
        end
        // polarity applied on the registered output
        nxt_state.out = nxt_state.level ^
                        nxt_state.ctl[twg_pkg::POL_INV_BIT];
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff.ctl <= twg_pkg::CTL_RESET;
            state_ff.level <= 1'b0;
            state_ff.out <= 1'b0;
            state_ff.rdata <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign reg_rdata = state_ff.rdata;
    assign timer_wave_out = state_ff.out;

    //------------------------------------------------------------------
    // checks
    //------------------------------------------------------------------
    logic pol_inv;
    logic sw_bit;
    logic live;
    logic end_ev;

    assign pol_inv = state_ff.ctl[twg_pkg::POL_INV_BIT];
    assign sw_bit = state_ff.ctl[twg_pkg::SW_LEVEL_BIT];
    assign live = !capture_mode;
    // rebuilt from the pins so a broken decode cannot hide itself
    assign end_ev = paired ? match_partner :
                    (count_mode == twg_pkg::COUNT_DOWN) ? counter_zero :
                    counter_max;

    sw_level_follow_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && gen_mode == twg_pkg::GEN_SOFTWARE)
        |=> state_ff.level == $past(sw_bit))
        else $error("software level not followed");

    sw_plain_out_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && gen_mode == twg_pkg::GEN_SOFTWARE && !pol_inv)
        |=> (!$stable(state_ff.ctl) || timer_wave_out == sw_bit))
        else $error("software level not driven");

    sw_invert_out_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && gen_mode == twg_pkg::GEN_SOFTWARE && pol_inv)
        |=> (!$stable(state_ff.ctl) || timer_wave_out != sw_bit))
        else $error("inverted software level wrong");

    capture_freeze_a: assert property (
        @(posedge clk) disable iff (reset)
        capture_mode |=> $stable(state_ff.level))
        else $error("level moved in capture mode");

    capture_out_a: assert property (
        @(posedge clk) disable iff (reset)
        capture_mode
        |=> (!$stable(state_ff.ctl) || $stable(timer_wave_out)))
        else $error("output moved in capture mode");

    reset_set_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && gen_mode == twg_pkg::GEN_RESET_SET && match_own && !end_ev)
        |=> !state_ff.level)
        else $error("mode 7 match did not clear");

    reset_set_end_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && gen_mode == twg_pkg::GEN_RESET_SET && end_ev && !match_own)
        |=> state_ff.level)
        else $error("mode 7 set missed");

    toggle_set_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && gen_mode == twg_pkg::GEN_TOGGLE_SET && end_ev)
        |=> state_ff.level)
        else $error("mode 6 set missed");

    toggle_set_match_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && gen_mode == twg_pkg::GEN_TOGGLE_SET && match_own && !end_ev)
        |=> state_ff.level != $past(state_ff.level))
        else $error("mode 6 toggle missed");

    reset_only_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && gen_mode == twg_pkg::GEN_RESET &&
         (match_own || (paired && match_partner)))
        |=> !state_ff.level)
        else $error("mode 5 clear missed");

    toggle_only_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && gen_mode == twg_pkg::GEN_TOGGLE && paired && match_partner)
        |=> state_ff.level != $past(state_ff.level))
        else $error("mode 4 paired toggle missed");

    toggle_own_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && gen_mode == twg_pkg::GEN_TOGGLE && match_own)
        |=> state_ff.level != $past(state_ff.level))
        else $error("mode 4 toggle missed");

    set_reset_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && gen_mode == twg_pkg::GEN_SET_RESET && end_ev)
        |=> !state_ff.level)
        else $error("mode 3 end reset missed");

    set_reset_match_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && gen_mode == twg_pkg::GEN_SET_RESET && match_own && !end_ev)
        |=> state_ff.level)
        else $error("mode 3 set missed");

    toggle_reset_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && gen_mode == twg_pkg::GEN_TOGGLE_RESET && end_ev)
        |=> !state_ff.level)
        else $error("mode 2 clear missed");

    toggle_reset_match_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && gen_mode == twg_pkg::GEN_TOGGLE_RESET && match_own &&
         !end_ev)
        |=> state_ff.level != $past(state_ff.level))
        else $error("mode 2 toggle missed");

    set_only_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && gen_mode == twg_pkg::GEN_SET &&
         (match_own || (paired && match_partner)))
        |=> state_ff.level)
        else $error("mode 1 set missed");

    pair_off_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && !paired && !match_own &&
         (gen_mode == twg_pkg::GEN_SET || gen_mode == twg_pkg::GEN_TOGGLE ||
          gen_mode == twg_pkg::GEN_RESET))
        |=> $stable(state_ff.level))
        else $error("level moved on partner while unpaired");

    pair_on_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && paired && !match_own && !match_partner &&
         gen_mode != twg_pkg::GEN_SOFTWARE)
        |=> $stable(state_ff.level))
        else $error("level moved without a match while paired");

    clash_set_a: assert property (
        @(posedge clk) disable iff (reset)
        (live && gen_mode == twg_pkg::GEN_RESET_SET && match_own && end_ev)
        |=> state_ff.level)
        else $error("mode 7 collision not set");

    polarity_out_a: assert property (
        @(posedge clk) disable iff (reset)
        timer_wave_out == (state_ff.level ^ pol_inv))
        else $error("output polarity wrong");

    // read data only after a read
    rdata_idle_a: assert property (
        @(posedge clk) disable iff (reset)
        !reg_read |=> reg_rdata == 16'h0000)
        else $error("read data not idle");

    // control read back
    rdata_ctl_a: assert property (
        @(posedge clk) disable iff (reset)
        (reg_read && reg_addr == twg_pkg::CTL_ADDR)
        |=> reg_rdata == $past(state_ff.ctl))
        else $error("control read back wrong");

    // status shows the level
    rdata_stat_a: assert property (
        @(posedge clk) disable iff (reset)
        (reg_read && reg_addr == twg_pkg::STAT_ADDR)
        |=> reg_rdata == {15'h0000, $past(state_ff.level)})
        else $error("status read back wrong");

    // control write lands
    ctl_write_a: assert property (
        @(posedge clk) disable iff (reset)
        (reg_write && reg_addr == twg_pkg::CTL_ADDR)
        |=> state_ff.ctl == $past(reg_wdata))
        else $error("control write lost");

    // other writes leave control alone
    ctl_hold_a: assert property (
        @(posedge clk) disable iff (reset)
        !(reg_write && reg_addr == twg_pkg::CTL_ADDR)
        |=> $stable(state_ff.ctl))
        else $error("control changed without a write");

endmodule

/* logic/twg_pkg.sv */
//----------------------------------------------------------------------
// Operation
//----------------------------------------------------------------------
package twg_pkg;

    // register map
    localparam logic [3:0] CTL_ADDR = 4'h0;
    localparam logic [3:0] STAT_ADDR = 4'h1;
    localparam logic [15:0] CTL_RESET = 16'h0000;

    // control field positions
    localparam int CAPTURE_MODE_BIT = 0;
    localparam int POL_INV_BIT = 1;
    localparam int GEN_MODE_LSB = 2;
    localparam int SW_LEVEL_BIT = 5;
    localparam int PAIR_SEL_BIT = 6;
    localparam int CTL_WIDTH = 16;

    // count directions
    localparam logic [1:0] COUNT_UP = 2'h0;
    localparam logic [1:0] COUNT_DOWN = 2'h1;
    localparam logic [1:0] COUNT_UPDOWN = 2'h2;

    typedef enum logic [2:0] {
        GEN_SOFTWARE,
        GEN_SET,
        GEN_TOGGLE_RESET,
        GEN_SET_RESET,
        GEN_TOGGLE,
        GEN_RESET,
        GEN_TOGGLE_SET,
        GEN_RESET_SET
    } twg_gen_mode_type;

endpackage

/* tb/twg_timer_output_waveform_gen_tb.sv */
`timescale 1ns/1ps
module twg_timer_output_waveform_gen_tb;
    logic        clk = 1'b0;
    logic        reset = 1'b1;
    logic [3:0]  reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic [15:0] reg_rdata;
    logic [1:0]  count_mode = 2'h0;
    logic [3:0]  evs = 4'h0;
    logic        timer_wave_out;
    int          n_fail = 0;
    int          num_checks = 0;
    logic [15:0] rv;
    logic        lvl;
    // own, partner, max, zero; includes set/clear collisions
    logic [3:0]  seq [8] = '{4'h8, 4'h2, 4'h8, 4'h4, 4'h1, 4'ha, 4'h5, 4'h8};

    twg_timer_output_waveform_gen twg_timer_output_waveform_gen_i (
        .clk(clk), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .count_mode(count_mode),
        .match_own(evs[3]), .match_partner(evs[2]),
        .counter_max(evs[1]), .counter_zero(evs[0]),
        .timer_wave_out(timer_wave_out));

    initial begin
        forever #2 clk = ~clk;
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        rv = reg_rdata;
    endtask

    task automatic ev(input logic [3:0] e);
        @(posedge clk);
        evs <= e;
        @(posedge clk);
        evs <= 4'h0;
        #1;
    endtask

    task automatic out_is(input logic e);
        // the software level lags a control write by one more edge; an event lands on the last edge of ev
        @(posedge clk);
        #1;
        chk("wave", {15'h0, e}, {15'h0, timer_wave_out});
    endtask

    // reference level after one event cycle; modes 2 and 3 let clear win
    function automatic logic nxt_lvl(input logic [2:0] m, input logic p,
                                     input logic l, input logic [3:0] e,
                                     input logic [1:0] cm);
        logic o, a, en, s, c, t;
        o  = e[3];
        a  = e[3] | (p & e[2]);
        en = p ? e[2] : ((cm == twg_pkg::COUNT_DOWN) ? e[0] : e[1]);
        s  = (m == 3'h1) ? a : (m == 3'h3) ? o : (m >= 3'h6) ? en : 1'b0;
        c  = (m == 3'h5) ? a : (m == 3'h7) ? o :
             (m == 3'h2 || m == 3'h3) ? en : 1'b0;
        t  = (m == 3'h4) ? a : (m == 3'h2 || m == 3'h6) ? o : 1'b0;
        if (m == 3'h2 || m == 3'h3)
            return c ? 1'b0 : s ? 1'b1 : t ? ~l : l;
        return s ? 1'b1 : c ? 1'b0 : t ? ~l : l;
    endfunction

    task automatic t_soft;
        rd(twg_pkg::CTL_ADDR);
        chk("ctl reset", twg_pkg::CTL_RESET, rv);
        wr(twg_pkg::CTL_ADDR, 16'h0020);
        out_is(1'b1);
        rd(twg_pkg::CTL_ADDR);
        chk("ctl", 16'h0020, rv);
        wr(twg_pkg::CTL_ADDR, 16'h0000);
        out_is(1'b0);
        wr(twg_pkg::CTL_ADDR, 16'h0022);
        out_is(1'b0);
        wr(twg_pkg::CTL_ADDR, 16'h0002);
        out_is(1'b1);
        rd(twg_pkg::STAT_ADDR);
        chk("status", 16'h0000, {15'h0, rv[0]});
    endtask

    task automatic t_capture;
        wr(twg_pkg::CTL_ADDR, 16'h0020);
        wr(twg_pkg::CTL_ADDR, 16'h0001);
        out_is(1'b1);
        wr(twg_pkg::CTL_ADDR, 16'h0051);
        ev(4'h8);
        ev(4'ha);
        out_is(1'b1);
        rd(twg_pkg::STAT_ADDR);
        chk("status", 16'h0001, {15'h0, rv[0]});
        wr(4'h5, 16'h0000);
        rd(4'h5);
        chk("unmapped", 16'h0000, rv);
        rd(twg_pkg::CTL_ADDR);
        chk("ctl", 16'h0051, rv);
    endtask

    task automatic t_modes;
        for (int cm = 0; cm < 3; cm++) begin
            for (int p = 0; p < 2; p++) begin
                for (int m = 0; m < 8; m++) begin
                    @(posedge clk);
                    count_mode <= cm[1:0];
                    wr(twg_pkg::CTL_ADDR, 16'h0000);
                    lvl = 1'b0;
                    wr(twg_pkg::CTL_ADDR, {9'h0, p[0], 1'b0, m[2:0], 2'b00});
                    for (int i = 0; i < 8; i++) begin
                        ev(seq[i]);
                        lvl = nxt_lvl(m[2:0], p[0], lvl, seq[i], cm[1:0]);
                        out_is(lvl);
                    end
                end
            end
        end
    endtask

    task automatic t_reset;
        wr(twg_pkg::CTL_ADDR, 16'h0020);
        out_is(1'b1);
        wr(twg_pkg::STAT_ADDR, 16'h0000);
        rd(twg_pkg::CTL_ADDR);
        chk("ctl kept", 16'h0020, rv);
        @(posedge clk);
        reset <= 1'b1;
        repeat (2) @(posedge clk);
        reset <= 1'b0;
        out_is(1'b0);
        rd(twg_pkg::CTL_ADDR);
        chk("ctl after reset", twg_pkg::CTL_RESET, rv);
    endtask

    initial begin
        #200000;
        n_fail++;
        wrap_up();
    end

    initial begin
        repeat (5) @(posedge clk);
        reset <= 1'b0;
        t_soft();
        t_capture();
        t_modes();
        t_reset();
        wrap_up();
    end
endmodule
